/* src/aocc_clk_mon.sv */
/*
  External clock presence monitor on the shared pin.
  Assumes the pin is asynchronous; it is synchronised here before use.
  Pulses appear_evt / vanish_evt for one cycle on each presence change.
*/
`timescale 1ns/10ps
module aocc_clk_mon
  import aocc_pkg::*;
(
  input  logic clk_sys,
  input  logic reset,
  input  logic clock_pin_in,
  input  logic monitor_on,
  output logic present,
  output logic appear_evt,
  output logic vanish_evt
);

  logic       s1_reg, s2_reg, s3_reg;  // Synchroniser and edge history
  logic [7:0] cnt_reg, cnt_next;       // Cycles since last edge
  logic       pres_reg, pres_next;
  logic       app_reg, van_reg;
  logic       pin_edge;

  // Limitation: clocks above half of clk_sys alias and may be missed
  assign pin_edge   = s2_reg ^ s3_reg;
  assign present    = pres_reg;
  assign appear_evt = app_reg;
  assign vanish_evt = van_reg;

  // ==========================================================================
  // Presence timer
  always_comb begin
    cnt_next  = cnt_reg;
    pres_next = pres_reg;
    if (!monitor_on) begin
      cnt_next  = 8'h00;
      pres_next = 1'b0;
    end else if (pin_edge) begin
      cnt_next  = 8'h00;
      pres_next = 1'b1;
    end else if (cnt_reg == 8'(AOCC_ABSENT_CYCLES - 1)) begin
      pres_next = 1'b0;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      cnt_reg  <= 8'h00;
      pres_reg <= 1'b0;
      app_reg  <= 1'b0;
      van_reg  <= 1'b0;
    end else begin
      s1_reg   <= clock_pin_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      cnt_reg  <= cnt_next;
      pres_reg <= pres_next;
      app_reg  <= pres_next & ~pres_reg;
      van_reg  <= ~pres_next & pres_reg;
    end
  end

endmodule

/* src/aocc_delay.sv */
/*
  Delay sequencer for one auxiliary output: follows the synchronised
  enable pin level after a programmed startup or shutdown delay.
  Assumes en_level is already synchronised to clk_sys.
*/
`timescale 1ns/10ps
module aocc_delay
  import aocc_pkg::*;
#(
  parameter int STEP_CYCLES = AOCC_STEP_CYCLES
) (
  input  logic       clk_sys,
  input  logic       reset,
  input  logic       en_level,
  input  logic [3:0] start_code,
  input  logic [3:0] stop_code,
  input  logic       start_range,
  input  logic       stop_range,
  output logic       delayed_level
);

  localparam int PW = $clog2(STEP_CYCLES + 1);

  aocc_dly_state_t state_reg, state_next;  // Sequencer state
  logic [PW-1:0]   pre_reg,   pre_next;    // Half-ms prescaler
  logic [4:0]      tick_reg,  tick_next;   // Remaining steps
  logic [4:0]      start_ticks;
  logic [4:0]      stop_ticks;
  logic            step_done;

  assign start_ticks   = aocc_step_ticks(start_code, start_range);
  assign stop_ticks    = aocc_step_ticks(stop_code, stop_range);
  assign step_done     = (pre_reg == PW'(STEP_CYCLES - 1));
  assign delayed_level = (state_reg == AOCC_DLY_HIGH) || (state_reg == AOCC_DLY_FALL);

  // ==========================================================================
  // Next state
  // Prescaler restarts on every load, so a delay is exact to one cycle
  always_comb begin
    state_next = state_reg;
    pre_next   = pre_reg;
    tick_next  = tick_reg;
    case (state_reg)
      AOCC_DLY_LOW: begin
        if (en_level) begin
          pre_next   = '0;
          tick_next  = start_ticks;
          state_next = (start_ticks == 5'h00) ? AOCC_DLY_HIGH : AOCC_DLY_RISE;
        end
      end
      AOCC_DLY_RISE: begin
        if (!en_level) begin
          state_next = AOCC_DLY_LOW;  // Aborted startup, never rose
        end else if (step_done) begin
          pre_next  = '0;
          tick_next = tick_reg - 5'h01;
          if (tick_reg == 5'h01) begin
            state_next = AOCC_DLY_HIGH;
          end
        end else begin
          pre_next = pre_reg + PW'(1);
        end
      end
      AOCC_DLY_HIGH: begin
        if (!en_level) begin
          pre_next   = '0;
          tick_next  = stop_ticks;
          state_next = (stop_ticks == 5'h00) ? AOCC_DLY_LOW : AOCC_DLY_FALL;
        end
      end
      AOCC_DLY_FALL: begin
        if (en_level) begin
          state_next = AOCC_DLY_HIGH;  // Aborted shutdown, stays high
        end else if (step_done) begin
          pre_next  = '0;
          tick_next = tick_reg - 5'h01;
          if (tick_reg == 5'h01) begin
            state_next = AOCC_DLY_LOW;
          end
        end else begin
          pre_next = pre_reg + PW'(1);
        end
      end
      default: state_next = AOCC_DLY_LOW;
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= AOCC_DLY_LOW;
      pre_reg   <= '0;
      tick_reg  <= 5'h00;
    end else begin
      state_reg <= state_next;
      pre_reg   <= pre_next;
      tick_reg  <= tick_next;
    end
  end

  // ==========================================================================
  // Checks
  a_start_load: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == AOCC_DLY_LOW && en_level && start_ticks != 5'h00)
      |=> (state_reg == AOCC_DLY_RISE && tick_reg == $past(start_ticks)))
    else $error("startup delay not loaded");
  a_stop_load: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == AOCC_DLY_HIGH && !en_level && stop_ticks != 5'h00)
      |=> (state_reg == AOCC_DLY_FALL && tick_reg == $past(stop_ticks)))
    else $error("shutdown delay not loaded");
  a_zero_rise: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == AOCC_DLY_LOW && en_level && start_ticks == 5'h00) |=> delayed_level)
    else $error("zero delay did not rise at once");

endmodule

/* src/aocc_pkg.sv */
/*
  Constants, carrier types and helper functions for the auxiliary output,
  system configuration and clock source control register bank.
  Assumes a single 40 MHz system clock and a serial front end outside this
  block that turns host transfers into one-cycle register read/write strobes.
*/
package aocc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] AOCC_ADDR_AUX_CTRL = 8'h12;  // aux_output_control
  localparam logic [7:0] AOCC_ADDR_SYS_CFG  = 8'h13;  // system_configuration
  localparam logic [7:0] AOCC_ADDR_CLK_CTRL = 8'h14;  // clock_source_control

  // Reset values
  localparam logic [7:0] AOCC_RST_AUX_CTRL  = 8'h44;  // Both drive types open-drain
  localparam logic [7:0] AOCC_RST_SYS_CFG   = 8'h1F;  // Clock pin, pulldowns, 137 C, spread on
  localparam logic [7:0] AOCC_RST_CLK_CTRL  = 8'h01;  // PLL off, 2 MHz code

  // Writable bits; reserved bits 7 and 3 of the aux register read zero
  localparam logic [7:0] AOCC_WMASK_AUX     = 8'h77;
  localparam logic [7:0] AOCC_WMASK_FULL    = 8'hFF;
  localparam logic [7:0] AOCC_RDATA_NONE    = 8'h00;  // Unmapped address answer

  // ==========================================================================
  // Timing
  localparam int AOCC_CLK_PERIOD_NS   = 25;
  localparam int AOCC_STEP_TIME_NS    = 500000;       // 0.5 ms delay step
  localparam int AOCC_STEP_CYCLES     = (AOCC_STEP_TIME_NS + AOCC_CLK_PERIOD_NS - 1) / AOCC_CLK_PERIOD_NS;
  localparam int AOCC_ABSENT_TIME_NS  = 2000;         // No clock edge for 2 us means absent
  localparam int AOCC_ABSENT_CYCLES   = AOCC_ABSENT_TIME_NS / AOCC_CLK_PERIOD_NS;

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic rsv_hi;                  // Reads zero
    logic b_drive_type;            // 0 push-pull, 1 open-drain
    logic b_pin_gating;            // Enable pin joins control
    logic b_level;                 // Second output level
    logic rsv_lo;                  // Reads zero
    logic a_drive_type;
    logic a_pin_gating;
    logic a_level;
  } aocc_aux_ctrl_t;

  typedef struct packed {
    logic rsv;                     // Stored, no effect
    logic startup_range;           // 0 half-ms steps, 1 ms steps
    logic shutdown_range;
    logic shared_pin_function;     // 0 output, 1 clock input
    logic clock_pin_pulldown;
    logic enable_pin_pulldown;
    logic thermal_warn_threshold;  // 0 125 C, 1 137 C
    logic spread_spectrum_on;
  } aocc_sys_cfg_t;

  typedef struct packed {
    logic       rsv_hi;
    logic       pll_enable;
    logic       rsv_b5;            // Host keeps it zero
    logic [4:0] external_clock_freq_code;
  } aocc_clk_ctrl_t;

  // Register access strobe group from the serial front end
  typedef struct packed {
    logic       wr;                // One-cycle write strobe
    logic       rd;                // One-cycle read strobe
    logic [7:0] addr;
    logic [7:0] wdata;
  } aocc_reg_req_t;

  // Delay sequencer states
  typedef enum logic [1:0] {
    AOCC_DLY_LOW  = 2'b00,
    AOCC_DLY_RISE = 2'b01,
    AOCC_DLY_HIGH = 2'b10,
    AOCC_DLY_FALL = 2'b11
  } aocc_dly_state_t;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] aocc_masked_write(input logic [7:0] cur, input logic [7:0] wd,
                                                    input logic [7:0] mask);
    return (cur & ~mask) | (wd & mask);
  endfunction

  // Delay code in half-ms ticks; wide range doubles each step
  function automatic logic [4:0] aocc_step_ticks(input logic [3:0] code, input logic wide);
    return wide ? {code, 1'b0} : {1'b0, code};
  endfunction

  // Frequency code to MHz
  function automatic logic [5:0] aocc_freq_mhz(input logic [4:0] code);
    return {1'b0, code} + 6'h01;
  endfunction

  // Pin value and type to {out, oe_n}; open-drain releases for high
  function automatic logic [1:0] aocc_pin_drive(input logic value, input logic open_drain);
    return open_drain ? {1'b0, value} : {value, 1'b0};
  endfunction

endpackage

/* src/aocc_regs.sv */
/*
  Auxiliary output, system configuration and clock source control registers
  with the output pin logic they steer.
  Assumes a serial front end delivering one-cycle read/write strobes on
  clk_sys, and the two auxiliary delay codes from the neighbouring registers.
*/
`timescale 1ns/10ps
module aocc_regs
  import aocc_pkg::*;
#(
  parameter int STEP_CYCLES = AOCC_STEP_CYCLES  // Half-ms step, shorten for simulation
) (
  input  logic          clk_sys,
  input  logic          reset,
  input  aocc_reg_req_t reg_req,                 // Register access strobes
  output logic [7:0]    reg_rdata,               // Read answer, one cycle after rd
  input  logic          enable_pin_in,           // Asynchronous enable pin
  input  logic          shared_pin_in,           // Shared pin level, clock input
  input  logic [7:0]    aux_a_delay_code,        // [7:4] shutdown, [3:0] startup
  input  logic [7:0]    aux_b_delay_code,
  output logic          aux_out_a,               // First output pin value
  output logic          aux_out_a_oe_n,          // Low while driving
  output logic          aux_out_b,               // Shared pin value
  output logic          aux_out_b_oe_n,
  output logic          clock_pin_pulldown,
  output logic          enable_pin_pulldown,
  output logic          thermal_warn_threshold,
  output logic          spread_spectrum_on,
  output logic          pll_enable,
  output logic          use_external_clock,
  output logic [5:0]    external_clock_freq_mhz,
  output logic          clock_event_irq          // One-cycle event pulse
);

  // ==========================================================================
  // Declarations
  // Register images hold the host view; pin and config flops hold the
  // values actually presented at the block boundary.
  // Each image is a packed struct so field names line up with the map.
  // Trade-off: one extra cycle of lag on every output, in exchange for
  // clean flop-driven pins with no glitch from decode logic.
  // Reserved bits of the aux register are never stored, so they read zero.
  // Reserved bits of the other two registers are stored but steer nothing.
  aocc_aux_ctrl_t aux_ctrl_reg, aux_ctrl_next;  // aux_output_control
  aocc_sys_cfg_t  sys_cfg_reg,  sys_cfg_next;   // system_configuration
  aocc_clk_ctrl_t clk_ctrl_reg, clk_ctrl_next;  // clock_source_control
  logic [7:0]     rdata_reg,    rdata_next;
  logic           en_s1_reg,    en_s2_reg;      // Enable pin synchroniser
  logic [1:0]     pin_a_reg,    pin_a_next;     // {out, oe_n}
  logic [1:0]     pin_b_reg,    pin_b_next;
  logic [5:0]     misc_reg,     misc_next;      // Pulldowns, thermal, spread, pll, ext
  logic [5:0]     freq_reg,     freq_next;
  logic           irq_reg,      irq_next;
  logic           dly_a;                        // Delayed enable for first output
  logic           dly_b;
  logic           clk_present;
  logic           clk_appear;
  logic           clk_vanish;
  logic           val_a;
  logic           val_b;

  // ==========================================================================
  // Enable pin delay sequencers
  // Both outputs watch the same synchronised enable level.
  // Each has its own startup and shutdown code from outside this block.
  // The range bits are shared, so a range change retimes both outputs.
  // Limitation: a range change in mid-delay only affects the next load.
  // Hazard avoided: the raw pin never reaches a sequencer unsynchronised.
  aocc_delay #(.STEP_CYCLES(STEP_CYCLES)) u_dly_a (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .en_level      (en_s2_reg),
    .start_code    (aux_a_delay_code[3:0]),
    .stop_code     (aux_a_delay_code[7:4]),
    .start_range   (sys_cfg_reg.startup_range),
    .stop_range    (sys_cfg_reg.shutdown_range),
    .delayed_level (dly_a)
  );

  aocc_delay #(.STEP_CYCLES(STEP_CYCLES)) u_dly_b (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .en_level      (en_s2_reg),
    .start_code    (aux_b_delay_code[3:0]),
    .stop_code     (aux_b_delay_code[7:4]),
    .start_range   (sys_cfg_reg.startup_range),
    .stop_range    (sys_cfg_reg.shutdown_range),
    .delayed_level (dly_b)
  );

  // External clock watch, only while PLL on and pin is the clock input
  aocc_clk_mon u_clk_mon (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .clock_pin_in (shared_pin_in),
    .monitor_on   (clk_ctrl_reg.pll_enable & sys_cfg_reg.shared_pin_function),
    .present      (clk_present),
    .appear_evt   (clk_appear),
    .vanish_evt   (clk_vanish)
  );

  // ==========================================================================
  // Register writes and reads
  // A write lands at the strobe edge and is visible one cycle later.
  // A read in the same cycle as a write returns the old value.
  // The read answer is held until the next read strobe, so a slow
  // front end may take it at any later cycle.
  // Unmapped reads answer zero; unmapped writes are dropped.
  always_comb begin
    aux_ctrl_next = aux_ctrl_reg;
    sys_cfg_next  = sys_cfg_reg;
    clk_ctrl_next = clk_ctrl_reg;
    rdata_next    = rdata_reg;
    if (reg_req.wr) begin
      case (reg_req.addr)
        AOCC_ADDR_AUX_CTRL: aux_ctrl_next = aocc_masked_write(aux_ctrl_reg, reg_req.wdata, AOCC_WMASK_AUX);
        AOCC_ADDR_SYS_CFG:  sys_cfg_next  = aocc_masked_write(sys_cfg_reg, reg_req.wdata, AOCC_WMASK_FULL);
        // Bit 5 stored as written; the host is trusted to keep it zero
        AOCC_ADDR_CLK_CTRL: clk_ctrl_next = aocc_masked_write(clk_ctrl_reg, reg_req.wdata, AOCC_WMASK_FULL);
        default: ;  // Unmapped write ignored
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        AOCC_ADDR_AUX_CTRL: rdata_next = aux_ctrl_reg;
        AOCC_ADDR_SYS_CFG:  rdata_next = sys_cfg_reg;
        AOCC_ADDR_CLK_CTRL: rdata_next = clk_ctrl_reg;
        default:            rdata_next = AOCC_RDATA_NONE;
      endcase
    end
  end

  // ==========================================================================
  // Output pin logic
  // Value first, then drive type turns it into {out, oe_n}.
  // Open-drain keeps out low and only releases oe_n for a high level,
  // so the external pull-up sets the high level.
  // Push-pull drives out directly with oe_n held low.
  // The shared pin is released whenever it serves as the clock input,
  // whatever the second output's level bit says.
  // Gating ANDs the level bit with the delayed enable state
  assign val_a = aux_ctrl_reg.a_level & (~aux_ctrl_reg.a_pin_gating | dly_a);
  assign val_b = aux_ctrl_reg.b_level & (~aux_ctrl_reg.b_pin_gating | dly_b);

  always_comb begin
    pin_a_next = aocc_pin_drive(val_a, aux_ctrl_reg.a_drive_type);
    if (sys_cfg_reg.shared_pin_function) begin
      pin_b_next = 2'h1;  // Clock input: released, not driven
    end else begin
      pin_b_next = aocc_pin_drive(val_b, aux_ctrl_reg.b_drive_type);
    end
  end

  // ==========================================================================
  // Configuration and clock source outputs
  // External clock use needs both the PLL bit and a present clock;
  // presence is already cleared by the monitor when the PLL is off.
  // The event pulse is gated by the PLL bit again so that a stale
  // monitor event can never escape after the PLL has been turned off.
  // Registered so every top output comes from a flop; one cycle lag accepted
  always_comb begin
    misc_next = {sys_cfg_reg.clock_pin_pulldown,
                 sys_cfg_reg.enable_pin_pulldown,
                 sys_cfg_reg.thermal_warn_threshold,
                 sys_cfg_reg.spread_spectrum_on,
                 clk_ctrl_reg.pll_enable,
                 clk_ctrl_reg.pll_enable & clk_present};
    freq_next = aocc_freq_mhz(clk_ctrl_reg.external_clock_freq_code);
    irq_next  = clk_ctrl_reg.pll_enable & (clk_appear | clk_vanish);
  end

  // ==========================================================================
  // Registers
  // Synchronous reset loads the documented register values.
  // Pins come out of reset released, so nothing is driven until the
  // first cycle after release, when the register images take effect.
  // The enable synchroniser clears to the pulled-down idle level, which
  // keeps a false rising edge from starting a delay after reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aux_ctrl_reg <= AOCC_RST_AUX_CTRL;
      sys_cfg_reg  <= AOCC_RST_SYS_CFG;
      clk_ctrl_reg <= AOCC_RST_CLK_CTRL;
      rdata_reg    <= AOCC_RDATA_NONE;
      en_s1_reg    <= 1'b0;
      en_s2_reg    <= 1'b0;
      pin_a_reg    <= 2'h1;
      pin_b_reg    <= 2'h1;
      misc_reg     <= 6'h00;
      freq_reg     <= 6'h00;
      irq_reg      <= 1'b0;
    end else begin
      aux_ctrl_reg <= aux_ctrl_next;
      sys_cfg_reg  <= sys_cfg_next;
      clk_ctrl_reg <= clk_ctrl_next;
      rdata_reg    <= rdata_next;
      en_s1_reg    <= enable_pin_in;
      en_s2_reg    <= en_s1_reg;
      pin_a_reg    <= pin_a_next;
      pin_b_reg    <= pin_b_next;
      misc_reg     <= misc_next;
      freq_reg     <= freq_next;
      irq_reg      <= irq_next;
    end
  end

  assign reg_rdata               = rdata_reg;
  assign aux_out_a               = pin_a_reg[1];
  assign aux_out_a_oe_n          = pin_a_reg[0];
  assign aux_out_b               = pin_b_reg[1];
  assign aux_out_b_oe_n          = pin_b_reg[0];
  assign clock_pin_pulldown      = misc_reg[5];
  assign enable_pin_pulldown     = misc_reg[4];
  assign thermal_warn_threshold  = misc_reg[3];
  assign spread_spectrum_on      = misc_reg[2];
  assign pll_enable              = misc_reg[1];
  assign use_external_clock      = misc_reg[0];
  assign external_clock_freq_mhz = freq_reg;
  assign clock_event_irq         = irq_reg;

  // ==========================================================================
  // Checks
  // All checks run on clk_sys and sleep during reset.
  // Local copies of register fields keep the properties short.
  // Checks watch a flop output one cycle after its cause; a_pll_off_rc looks two cycles after, a_aux_rsv_zero in the same cycle.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic chk_a_lvl, chk_a_gate, chk_a_od, chk_pll, chk_b_fn;
  logic [4:0] chk_code;
  assign chk_a_lvl  = aux_ctrl_reg.a_level;
  assign chk_a_gate = aux_ctrl_reg.a_pin_gating;
  assign chk_a_od   = aux_ctrl_reg.a_drive_type;
  assign chk_pll    = clk_ctrl_reg.pll_enable;
  assign chk_b_fn   = sys_cfg_reg.shared_pin_function;
  assign chk_code   = clk_ctrl_reg.external_clock_freq_code;

  a_level_direct: assert property ((!chk_a_gate && !chk_a_od)
    |=> (aux_out_a == $past(chk_a_lvl) && !aux_out_a_oe_n))
    else $error("first output not following level bit");
  a_gate_blocks: assert property ((chk_a_gate && !dly_a && !chk_a_od) |=> !aux_out_a)
    else $error("gated output high without enable");
  a_gate_passes: assert property ((chk_a_gate && dly_a && chk_a_lvl && !chk_a_od) |=> aux_out_a)
    else $error("gated output low with enable and level");
  a_b_gate_pass: assert property ((!chk_b_fn && !aux_ctrl_reg.b_drive_type && aux_ctrl_reg.b_level
    && (!aux_ctrl_reg.b_pin_gating || dly_b)) |=> (aux_out_b && !aux_out_b_oe_n))
    else $error("shared pin output not driven high");
  a_open_drain: assert property (chk_a_od |=> (!aux_out_a && aux_out_a_oe_n == $past(val_a)))
    else $error("open-drain output drove high");
  a_clock_release: assert property (chk_b_fn |=> aux_out_b_oe_n)
    else $error("shared pin driven while clock input");
  a_pll_off_rc: assert property (!chk_pll |=> ##1 (!use_external_clock && !clock_event_irq))
    else $error("external clock used with PLL off");
  a_irq_event: assert property ((chk_pll && (clk_appear || clk_vanish)) |=> clock_event_irq)
    else $error("clock change gave no interrupt");
  a_freq_map: assert property (1'b1 |=> (external_clock_freq_mhz == {1'b0, $past(chk_code)} + 6'h01))
    else $error("frequency code mapping wrong");
  a_ext_select: assert property ((chk_pll && clk_present) |=> use_external_clock)
    else $error("present external clock not used");
  // PLL bit must reach the pin one cycle after the register
  a_pll_bit_out: assert property (chk_pll |=> pll_enable)
    else $error("PLL enable not presented");
  a_pll_bit_off: assert property (!chk_pll |=> !pll_enable)
    else $error("PLL enable presented while off");
  // Unmapped address reads back zero
  a_unmapped_read: assert property ((reg_req.rd && reg_req.addr != AOCC_ADDR_AUX_CTRL
    && reg_req.addr != AOCC_ADDR_SYS_CFG && reg_req.addr != AOCC_ADDR_CLK_CTRL)
    |=> (reg_rdata == AOCC_RDATA_NONE))
    else $error("unmapped read not zero");
  // Reserved aux bits never stored
  a_aux_rsv_zero: assert property (!aux_ctrl_reg.rsv_hi && !aux_ctrl_reg.rsv_lo)
    else $error("reserved aux bit stored");

  c_irq:      cover property (clock_event_irq);
  c_gated_hi: cover property (chk_a_gate && dly_a && aux_out_a);
  c_b_output: cover property (!chk_b_fn && aux_out_b && !aux_out_b_oe_n);
  c_ext_use:  cover property (use_external_clock);
  c_b_gated:  cover property (aux_ctrl_reg.b_pin_gating && !dly_b && !aux_out_b);

endmodule

/* tb/aocc_host.sv */
/* Host model: issues register strobes as the serial front end would.
   Assumes read data is registered after the read strobe and then holds. */
`timescale 1ns/10ps
module aocc_host
  import aocc_pkg::*;
(
  input  logic          clk_sys,
  input  logic [7:0]    rdata,
  output aocc_reg_req_t reg_req
);
  initial reg_req = '0;
  // ==========================================================
  // One-cycle write; reserved clock bit always sent as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys); #2;
    reg_req = '{1'b1, 1'b0, a, (a == AOCC_ADDR_CLK_CTRL) ? (d & 8'hDF) : d};
    @(posedge clk_sys); #2;
    reg_req.wr = 1'b0;
  endtask
  // One-cycle read; sampled an edge later since the answer holds
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys); #2;
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys); #2;
    reg_req.rd = 1'b0;
    @(posedge clk_sys); #2;
    d = rdata;
  endtask
endmodule

/* tb/aux_output_clock_config_regs_bench.sv */
/* Bench for the register bank: register map, pin drive, gating delay,
   external clock events. Assumes the host model drives all strobes. */
`timescale 1ns/10ps
module aux_output_clock_config_regs_bench;
  import aocc_pkg::*;
  logic clk_sys = 0, reset = 1, en_pin = 0, ext_pin = 0;
  logic [7:0] rdv, rdata;
  logic [5:0] mhz;
  logic a_o, a_n, b_o, b_n, cpd, epd, thr, ssp, pll, uext, irq;
  aocc_reg_req_t req;
  int bad_count = 0, check_count = 0, cyc = 0, irq_n = 0;
  always #12.5 clk_sys = ~clk_sys;
  // ==========================================================
  aocc_host u_host (.clk_sys(clk_sys), .rdata(rdata), .reg_req(req));
  aocc_regs #(.STEP_CYCLES(4)) u_dut (.clk_sys(clk_sys), .reset(reset), .reg_req(req),
    .reg_rdata(rdata), .enable_pin_in(en_pin), .shared_pin_in(ext_pin), .aux_a_delay_code(8'h01),
    .aux_b_delay_code(8'h00), .aux_out_a(a_o), .aux_out_a_oe_n(a_n), .aux_out_b(b_o),
    .aux_out_b_oe_n(b_n), .clock_pin_pulldown(cpd), .enable_pin_pulldown(epd),
    .thermal_warn_threshold(thr), .spread_spectrum_on(ssp), .pll_enable(pll),
    .use_external_clock(uext), .external_clock_freq_mhz(mhz), .clock_event_irq(irq));
  // Count event pulses and cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (irq === 1'b1) irq_n++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, rdv);
    chk("rdata", rdv, exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #2 reset = 0;
    // Reset values, reserved bits, unmapped address
    rdchk(8'h12, 8'h44);
    rdchk(8'h13, 8'h1F);
    rdchk(8'h14, 8'h01);
    rdchk(8'h20, 8'h00);
    chk("pulldowns", {4'h0, cpd, epd, thr, ssp}, 8'h0F);
    u_host.wr(8'h12, 8'hFF);
    rdchk(8'h12, 8'h77);
    $display("test registers done");
    // Level and drive type of the first output
    u_host.wr(8'h12, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk("a push", {6'h00, a_o, a_n}, 8'h02);
    u_host.wr(8'h12, 8'h05);
    repeat (3) @(posedge clk_sys);
    chk("a open", {6'h00, a_o, a_n}, 8'h01);
    // Gating: waits for enable plus one startup step
    u_host.wr(8'h12, 8'h03);
    repeat (3) @(posedge clk_sys);
    chk("a gated", {7'h00, a_o}, 8'h00);
    #2 en_pin = 1;
    repeat (4) @(posedge clk_sys);
    chk("a early", {7'h00, a_o}, 8'h00);
    repeat (12) @(posedge clk_sys);
    chk("a late", {7'h00, a_o}, 8'h01);
    $display("test first output done");
    // Shared pin as output, gated by enable
    u_host.wr(8'h13, 8'h0F);
    u_host.wr(8'h12, 8'h30);
    repeat (6) @(posedge clk_sys);
    chk("b out", {6'h00, b_o, b_n}, 8'h02);
    #2 en_pin = 0;
    repeat (8) @(posedge clk_sys);
    chk("b off", {6'h00, b_o, b_n}, 8'h00);
    $display("test shared pin done");
    // Frequency code and external clock events
    u_host.wr(8'h14, 8'h17);
    repeat (3) @(posedge clk_sys);
    chk("mhz", {2'b00, mhz}, 8'h18);
    u_host.wr(8'h13, 8'h1F);
    u_host.wr(8'h14, 8'h41);
    repeat (40) #125 ext_pin = ~ext_pin;
    chk("uext", {6'h00, pll, uext}, 8'h03);
    ext_pin = 0;
    repeat (120) @(posedge clk_sys);
    chk("uext gone", {7'h00, uext}, 8'h00);
    chk("irq count", 8'(irq_n), 8'h02);
    $display("test clock monitor done");
    test_done();
  end
endmodule
